// file: rtl/diag_fault_pkg.sv
package diag_fault_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [15:0] ADDR_CELL_LOW_VOLTAGE_UPPER = 16'h053e;
   localparam logic [15:0] ADDR_CELL_LOW_VOLTAGE_LOWER = 16'h053f;
   localparam logic [15:0] ADDR_INPUT_HOT_FLAGS = 16'h0540;
   localparam logic [15:0] ADDR_INPUT_COLD_FLAGS = 16'h0541;
   localparam logic [15:0] ADDR_AUX_INPUT_COMPARE_FAIL = 16'h0543;
   localparam logic [15:0] ADDR_CELL_COMPARE_FAIL_UPPER = 16'h0545;
   localparam logic [15:0] ADDR_CELL_COMPARE_FAIL_LOWER = 16'h0546;
   localparam logic [15:0] ADDR_CELL_OPEN_WIRE_UPPER = 16'h0548;
   localparam logic [15:0] ADDR_CELL_OPEN_WIRE_LOWER = 16'h0549;
   localparam logic [15:0] ADDR_BALANCE_OPEN_WIRE_UPPER = 16'h054b;
   localparam logic [15:0] ADDR_BALANCE_OPEN_WIRE_LOWER = 16'h054c;
   localparam logic [15:0] ADDR_BALANCE_SWITCH_FAIL_UPPER = 16'h054e;
   localparam logic [15:0] ADDR_BALANCE_SWITCH_FAIL_LOWER = 16'h054f;
   localparam logic [15:0] ADDR_COMPARE_MISC_STATUS = 16'h0550;
   localparam logic [15:0] ADDR_POWER_FAULT_FIRST = 16'h0552;
   localparam logic [15:0] ADDR_POWER_FAULT_SECOND = 16'h0553;
   localparam logic [15:0] ADDR_POWER_FAULT_THIRD = 16'h0554;

   // ****************************************
   // field positions and reset value
   // ****************************************
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int MISC_ABORT_BIT = 1;
   localparam int MISC_FILTER_BIT = 0;
   localparam logic [7:0] MISC_VALID_MASK = 8'h03;
   localparam int PWR1_PUMP_GND_BIT = 7;
   localparam int PWR1_DIG_GND_BIT = 6;
   localparam int PWR1_REF_RET_BIT = 5;
   localparam int PWR1_PUMP_LOW_BIT = 4;
   localparam int PWR1_PUMP_HIGH_BIT = 3;
   localparam int PWR1_DIG_HIGH_BIT = 2;
   localparam int PWR1_ANA_OSC_BIT = 1;
   localparam int PWR1_ANA_HIGH_BIT = 0;
   localparam int PWR2_SELFTEST_BIT = 6;
   localparam int PWR2_HREF_OSC_BIT = 4;
   localparam int PWR2_NEG_LOW_BIT = 3;
   localparam int PWR2_SREF_OSC_BIT = 2;
   localparam int PWR2_SREF_LOW_BIT = 1;
   localparam int PWR2_SREF_HIGH_BIT = 0;
   localparam logic [7:0] PWR2_VALID_MASK = 8'h5f;
   localparam int PWR3_RESET_CAUSE_BIT = 0;
   localparam logic [7:0] PWR3_VALID_MASK = 8'h01;

   // ****************************************
   // threshold widths
   // ****************************************
   localparam int AUX_THR_W = 3;
   localparam int CELL_THR_W = 5;
   localparam int OPEN_WIRE_THRESHOLD_W = 4;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic pump_ground_open;
      logic digital_ground_open;
      logic ref_return_open;
      logic pump_supply_low;
      logic pump_supply_high;
      logic digital_supply_high;
      logic analog_supply_oscillating;
      logic analog_supply_high;
   } power_first_type;

   typedef struct packed {
      logic supply_selftest_fail;
      logic high_ref_oscillating;
      logic neg_pump_low;
      logic sensor_ref_oscillating;
      logic sensor_ref_low;
      logic sensor_ref_high;
   } power_second_type;

   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } host_req_type;

endpackage

// file: rtl/diag_fault_status_bank.sv
`timescale 1ns/100ps
`default_nettype none

// Contract
// - undervoltage flags cells 9..16, bit 0 = cell 9.
// - undervoltage flags cells 1..8, bit 0 = cell 1.
// - over-temperature flag per aux input 1..8, bit 0 = input 1.
// - under-temperature flag per aux input 1..8, bit 0 = input 1.
// - aux input fails when main/aux readings differ above 3-bit threshold.
// - cell fails when primary/aux readings differ above 5-bit threshold.
// - open-wire flag when cell voltage is below 4-bit threshold.
// - balancing-path open-wire fail flag per switch, upper and lower registers.
// - balancing-switch diagnostic fail flag per switch, upper and lower.
// - abort flag set when comparison diagnostic aborted for bad setting.
// - filter diagnostic outcome held in one misc flag, 1 = fail.
// - first power register bits 7..5 flag open grounds and reference return.
// - first power register bits 4,3,2,0 flag regulator faults.
// - bit 1 flags analog oscillation; host should ignore and clear it.
// - second power register bit 6 self-test fail; bits 7,5 read zero.
// - second power register bits 4..0 flag reference and pump faults.
// - third power register bit 0 records analog-undervoltage digital reset.
// - voltage summary set when mask clear and any undervoltage bit set.
// - power summary set when mask clear and any power bit set.
// - temperature summary set when mask clear and any over-temp bit set.
module diag_fault_status_bank #(
   parameter int CELLS = 16,
   parameter int INPUTS = 8
) (
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   // host register port
   input wire diag_fault_pkg::host_req_type I_HOST_REQ,
   output logic [7:0] O_RDATA,
   output logic O_RVALID,
   // measurement and comparator sources
   input wire logic [CELLS-1:0] I_CELL_LOW_VOLT_FLAG,
   input wire logic [INPUTS-1:0] I_INPUT_HOT_FLAG,
   input wire logic [INPUTS-1:0] I_INPUT_COLD_FLAG,
   input wire logic [INPUTS*16-1:0] I_AUX_MAIN_READING,
   input wire logic [INPUTS*16-1:0] I_AUX_AUX_READING,
   input wire logic [CELLS*16-1:0] I_CELL_MAIN_READING,
   input wire logic [CELLS*16-1:0] I_CELL_AUX_READING,
   input wire logic I_COMPARE_STROBE,
   input wire logic [diag_fault_pkg::AUX_THR_W-1:0] I_AUX_COMPARE_THRESHOLD,
   input wire logic [diag_fault_pkg::CELL_THR_W-1:0] I_CELL_COMPARE_THRESHOLD,
   input wire logic [diag_fault_pkg::OPEN_WIRE_THRESHOLD_W-1:0] I_OPEN_WIRE_THRESHOLD,
   input wire logic I_OPEN_WIRE_STROBE,
   input wire logic [CELLS-1:0] I_BALANCE_OPEN_WIRE_FLAG,
   input wire logic [CELLS-1:0] I_BALANCE_SWITCH_FLAG,
   input wire logic I_COMPARE_ABORT,
   input wire logic I_FILTER_DIAG_FLAG,
   input wire diag_fault_pkg::power_first_type I_POWER_FIRST,
   input wire diag_fault_pkg::power_second_type I_POWER_SECOND,
   input wire logic I_ANALOG_LOW_RESET_CAUSE,
   // clear strobe and summary masks
   input wire logic I_FAULT_CLEAR,
   input wire logic I_LOW_VOLT_SUMMARY_MASK,
   input wire logic I_HOT_SUMMARY_MASK,
   input wire logic I_POWER_SUMMARY_MASK,
   // summary flags
   output logic O_VOLTAGE_SUMMARY_FLAG,
   output logic O_TEMPERATURE_SUMMARY_FLAG,
   output logic O_POWER_SUMMARY_FLAG
);

   initial begin
      if (CELLS != 16 || INPUTS != 8) begin
         $error("bank layout serves exactly 16 cells and 8 inputs");
      end
   end

   // ****************************************
   // flag state
   // ****************************************
   logic [CELLS-1:0] cell_low_volt_ff;
   logic [INPUTS-1:0] input_hot_ff;
   logic [INPUTS-1:0] input_cold_ff;
   logic [INPUTS-1:0] aux_compare_ff;
   logic [CELLS-1:0] cell_compare_ff;
   logic [CELLS-1:0] cell_open_wire_ff;
   logic [CELLS-1:0] balance_open_wire_ff;
   logic [CELLS-1:0] balance_switch_ff;
   logic [7:0] misc_ff;
   logic [7:0] power_first_ff;
   logic [7:0] power_second_ff;
   logic [7:0] power_third_ff;
   logic [INPUTS-1:0] aux_compare_hit;
   logic [CELLS-1:0] cell_compare_hit;
   logic [CELLS-1:0] open_wire_hit;
   logic [7:0] misc_src;
   logic [7:0] power_second_src;
   logic [7:0] power_third_src;

   // ****************************************
   // comparison diagnostics
   // ****************************************
   // differences are unsigned magnitudes; thresholds are in reading lsbs
   genvar gi;
   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_cell
         logic [15:0] cm;
         logic [15:0] ca;
         logic [15:0] cdiff;
         assign cm = I_CELL_MAIN_READING[gi*16 +: 16];
         assign ca = I_CELL_AUX_READING[gi*16 +: 16];
         assign cdiff = (cm > ca) ? 16'(cm - ca) : 16'(ca - cm);
         assign cell_compare_hit[gi] = I_COMPARE_STROBE
            && (cdiff > 16'(I_CELL_COMPARE_THRESHOLD));
         assign open_wire_hit[gi] = I_OPEN_WIRE_STROBE
            && (cm < 16'(I_OPEN_WIRE_THRESHOLD));
         if (gi < INPUTS) begin : g_aux
            logic [15:0] am;
            logic [15:0] aa;
            logic [15:0] adiff;
            assign am = I_AUX_MAIN_READING[gi*16 +: 16];
            assign aa = I_AUX_AUX_READING[gi*16 +: 16];
            assign adiff = (am > aa) ? 16'(am - aa) : 16'(aa - am);
            assign aux_compare_hit[gi] = I_COMPARE_STROBE
               && (adiff > 16'(I_AUX_COMPARE_THRESHOLD));
         end
      end
   endgenerate

   always_comb begin
      misc_src = diag_fault_pkg::RESET_VALUE;
      misc_src[diag_fault_pkg::MISC_ABORT_BIT] = I_COMPARE_ABORT;
      misc_src[diag_fault_pkg::MISC_FILTER_BIT] = I_FILTER_DIAG_FLAG;
   end

   always_comb begin
      power_second_src = diag_fault_pkg::RESET_VALUE;
      power_second_src[diag_fault_pkg::PWR2_SELFTEST_BIT] =
         I_POWER_SECOND.supply_selftest_fail;
      power_second_src[diag_fault_pkg::PWR2_HREF_OSC_BIT] =
         I_POWER_SECOND.high_ref_oscillating;
      power_second_src[diag_fault_pkg::PWR2_NEG_LOW_BIT] = I_POWER_SECOND.neg_pump_low;
      power_second_src[diag_fault_pkg::PWR2_SREF_OSC_BIT] =
         I_POWER_SECOND.sensor_ref_oscillating;
      power_second_src[diag_fault_pkg::PWR2_SREF_LOW_BIT] = I_POWER_SECOND.sensor_ref_low;
      power_second_src[diag_fault_pkg::PWR2_SREF_HIGH_BIT] = I_POWER_SECOND.sensor_ref_high;
   end

   always_comb begin
      power_third_src = diag_fault_pkg::RESET_VALUE;
      power_third_src[diag_fault_pkg::PWR3_RESET_CAUSE_BIT] = I_ANALOG_LOW_RESET_CAUSE;
   end

   // ****************************************
   // sticky flags
   // ****************************************
   // a source event in the clear cycle wins, so no fault is lost
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         cell_low_volt_ff <= '0;
         input_hot_ff <= '0;
         input_cold_ff <= '0;
      end else begin
         cell_low_volt_ff <= (I_FAULT_CLEAR ? '0 : cell_low_volt_ff)
            | I_CELL_LOW_VOLT_FLAG;
         input_hot_ff <= (I_FAULT_CLEAR ? '0 : input_hot_ff) | I_INPUT_HOT_FLAG;
         input_cold_ff <= (I_FAULT_CLEAR ? '0 : input_cold_ff) | I_INPUT_COLD_FLAG;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         aux_compare_ff <= '0;
         cell_compare_ff <= '0;
         cell_open_wire_ff <= '0;
         balance_open_wire_ff <= '0;
         balance_switch_ff <= '0;
      end else begin
         aux_compare_ff <= (I_FAULT_CLEAR ? '0 : aux_compare_ff) | aux_compare_hit;
         cell_compare_ff <= (I_FAULT_CLEAR ? '0 : cell_compare_ff) | cell_compare_hit;
         cell_open_wire_ff <= (I_FAULT_CLEAR ? '0 : cell_open_wire_ff) | open_wire_hit;
         balance_open_wire_ff <= (I_FAULT_CLEAR ? '0 : balance_open_wire_ff)
            | I_BALANCE_OPEN_WIRE_FLAG;
         balance_switch_ff <= (I_FAULT_CLEAR ? '0 : balance_switch_ff)
            | I_BALANCE_SWITCH_FLAG;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         misc_ff <= diag_fault_pkg::RESET_VALUE;
         power_first_ff <= diag_fault_pkg::RESET_VALUE;
         power_second_ff <= diag_fault_pkg::RESET_VALUE;
         power_third_ff <= diag_fault_pkg::RESET_VALUE;
      end else begin
         misc_ff <= ((I_FAULT_CLEAR ? 8'h00 : misc_ff) | misc_src)
            & diag_fault_pkg::MISC_VALID_MASK;
         // struct order matches bit order 7..0; oscillation may be spurious on wake
         power_first_ff <= (I_FAULT_CLEAR ? 8'h00 : power_first_ff)
            | 8'(I_POWER_FIRST);
         power_second_ff <= ((I_FAULT_CLEAR ? 8'h00 : power_second_ff) | power_second_src)
            & diag_fault_pkg::PWR2_VALID_MASK;
         power_third_ff <= ((I_FAULT_CLEAR ? 8'h00 : power_third_ff) | power_third_src)
            & diag_fault_pkg::PWR3_VALID_MASK;
      end
   end

   // ****************************************
   // summary flags
   // ****************************************
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_VOLTAGE_SUMMARY_FLAG <= 1'b0;
         O_TEMPERATURE_SUMMARY_FLAG <= 1'b0;
         O_POWER_SUMMARY_FLAG <= 1'b0;
      end else begin
         O_VOLTAGE_SUMMARY_FLAG <= !I_LOW_VOLT_SUMMARY_MASK && (|cell_low_volt_ff);
         O_TEMPERATURE_SUMMARY_FLAG <= !I_HOT_SUMMARY_MASK && (|input_hot_ff);
         O_POWER_SUMMARY_FLAG <= !I_POWER_SUMMARY_MASK
            && (|{power_first_ff, power_second_ff, power_third_ff});
      end
   end

   // ****************************************
   // host read port
   // ****************************************
   // writes are dropped: every register here is status only
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= diag_fault_pkg::RESET_VALUE;
         O_RVALID <= 1'b0;
      end else begin
         O_RVALID <= I_HOST_REQ.re;
         if (I_HOST_REQ.re) begin
            case (I_HOST_REQ.addr)
               diag_fault_pkg::ADDR_CELL_LOW_VOLTAGE_UPPER: O_RDATA <= cell_low_volt_ff[15:8];
               diag_fault_pkg::ADDR_CELL_LOW_VOLTAGE_LOWER: O_RDATA <= cell_low_volt_ff[7:0];
               diag_fault_pkg::ADDR_INPUT_HOT_FLAGS: O_RDATA <= input_hot_ff;
               diag_fault_pkg::ADDR_INPUT_COLD_FLAGS: O_RDATA <= input_cold_ff;
               diag_fault_pkg::ADDR_AUX_INPUT_COMPARE_FAIL: O_RDATA <= aux_compare_ff;
               diag_fault_pkg::ADDR_CELL_COMPARE_FAIL_UPPER: O_RDATA <= cell_compare_ff[15:8];
               diag_fault_pkg::ADDR_CELL_COMPARE_FAIL_LOWER: O_RDATA <= cell_compare_ff[7:0];
               diag_fault_pkg::ADDR_CELL_OPEN_WIRE_UPPER: O_RDATA <= cell_open_wire_ff[15:8];
               diag_fault_pkg::ADDR_CELL_OPEN_WIRE_LOWER: O_RDATA <= cell_open_wire_ff[7:0];
               diag_fault_pkg::ADDR_BALANCE_OPEN_WIRE_UPPER: begin
                  O_RDATA <= balance_open_wire_ff[15:8];
               end
               diag_fault_pkg::ADDR_BALANCE_OPEN_WIRE_LOWER: begin
                  O_RDATA <= balance_open_wire_ff[7:0];
               end
               diag_fault_pkg::ADDR_BALANCE_SWITCH_FAIL_UPPER: begin
                  O_RDATA <= balance_switch_ff[15:8];
               end
               diag_fault_pkg::ADDR_BALANCE_SWITCH_FAIL_LOWER: begin
                  O_RDATA <= balance_switch_ff[7:0];
               end
               diag_fault_pkg::ADDR_COMPARE_MISC_STATUS: O_RDATA <= misc_ff;
               diag_fault_pkg::ADDR_POWER_FAULT_FIRST: O_RDATA <= power_first_ff;
               diag_fault_pkg::ADDR_POWER_FAULT_SECOND: O_RDATA <= power_second_ff;
               diag_fault_pkg::ADDR_POWER_FAULT_THIRD: O_RDATA <= power_third_ff;
               default: O_RDATA <= diag_fault_pkg::RESET_VALUE;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// file: sim/diag_fault_status_bank_sva.sv
`timescale 1ns/100ps
`default_nettype none
module diag_fault_status_bank_sva #(
   parameter int CELLS = 16
) (
   // clock, reset and host port
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire diag_fault_pkg::host_req_type I_HOST_REQ,
   input wire logic [7:0] O_RDATA,
   input wire logic O_RVALID,
   // sources, clear, masks and summaries
   input wire logic [CELLS-1:0] I_CELL_LOW_VOLT_FLAG,
   input wire diag_fault_pkg::power_first_type I_POWER_FIRST,
   input wire logic I_FAULT_CLEAR,
   input wire logic I_LOW_VOLT_SUMMARY_MASK,
   input wire logic I_HOT_SUMMARY_MASK,
   input wire logic I_POWER_SUMMARY_MASK,
   input wire logic O_VOLTAGE_SUMMARY_FLAG,
   input wire logic O_TEMPERATURE_SUMMARY_FLAG,
   input wire logic O_POWER_SUMMARY_FLAG
);
   // ****************************************
   // read port and summary checks
   // ****************************************
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RST);
   property p_answer; I_HOST_REQ.re |=> O_RVALID; endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   property p_no_stray; O_RVALID |-> $past(I_HOST_REQ.re); endproperty
   a_no_stray: assert property (p_no_stray) else $error("answer without read");
   property p_hold; !I_HOST_REQ.re |=> $stable(O_RDATA); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_pwr2_rsvd; I_HOST_REQ.re && I_HOST_REQ.addr == diag_fault_pkg::ADDR_POWER_FAULT_SECOND
      |=> (O_RDATA & ~diag_fault_pkg::PWR2_VALID_MASK) == 8'h00; endproperty
   a_pwr2_rsvd: assert property (p_pwr2_rsvd) else $error("second power reserved set");
   property p_pwr3_rsvd; I_HOST_REQ.re && I_HOST_REQ.addr == diag_fault_pkg::ADDR_POWER_FAULT_THIRD
      |=> (O_RDATA & ~diag_fault_pkg::PWR3_VALID_MASK) == 8'h00; endproperty
   a_pwr3_rsvd: assert property (p_pwr3_rsvd) else $error("third power reserved set");
   property p_misc_rsvd; I_HOST_REQ.re && I_HOST_REQ.addr == diag_fault_pkg::ADDR_COMPARE_MISC_STATUS
      |=> (O_RDATA & ~diag_fault_pkg::MISC_VALID_MASK) == 8'h00; endproperty
   a_misc_rsvd: assert property (p_misc_rsvd) else $error("misc reserved set");
   property p_volt_sum; (|I_CELL_LOW_VOLT_FLAG && !I_FAULT_CLEAR && !I_LOW_VOLT_SUMMARY_MASK)
      ##1 (!I_FAULT_CLEAR && !I_LOW_VOLT_SUMMARY_MASK)[*2] |=> O_VOLTAGE_SUMMARY_FLAG; endproperty
   a_volt_sum: assert property (p_volt_sum) else $error("voltage summary missing");
   property p_pwr_sum; (|I_POWER_FIRST && !I_FAULT_CLEAR && !I_POWER_SUMMARY_MASK)
      ##1 (!I_FAULT_CLEAR && !I_POWER_SUMMARY_MASK)[*2] |=> O_POWER_SUMMARY_FLAG; endproperty
   a_pwr_sum: assert property (p_pwr_sum) else $error("power summary missing");
   property p_hot_mask; I_HOT_SUMMARY_MASK[*3] |-> !O_TEMPERATURE_SUMMARY_FLAG; endproperty
   a_hot_mask: assert property (p_hot_mask) else $error("masked temperature summary");
endmodule
bind diag_fault_status_bank diag_fault_status_bank_sva #(.CELLS(CELLS)) i_sva (
   .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_HOST_REQ(I_HOST_REQ), .O_RDATA(O_RDATA),
   .O_RVALID(O_RVALID), .I_CELL_LOW_VOLT_FLAG(I_CELL_LOW_VOLT_FLAG),
   .I_POWER_FIRST(I_POWER_FIRST), .I_FAULT_CLEAR(I_FAULT_CLEAR),
   .I_LOW_VOLT_SUMMARY_MASK(I_LOW_VOLT_SUMMARY_MASK), .I_HOT_SUMMARY_MASK(I_HOT_SUMMARY_MASK),
   .I_POWER_SUMMARY_MASK(I_POWER_SUMMARY_MASK), .O_VOLTAGE_SUMMARY_FLAG(O_VOLTAGE_SUMMARY_FLAG),
   .O_TEMPERATURE_SUMMARY_FLAG(O_TEMPERATURE_SUMMARY_FLAG),
   .O_POWER_SUMMARY_FLAG(O_POWER_SUMMARY_FLAG));
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // clock and answer
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   // request
   output var diag_fault_pkg::host_req_type o_req
);
   // ****************************************
   // request tasks, entered at a falling edge
   // ****************************************
   initial o_req = '0;
   // no release between reads, so reads run back to back
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      o_req = '{re: 1'b1, we: 1'b0, addr: a, wdata: ~o_req.wdata};
      @(negedge i_clk);
      d = i_rdata;
      v = i_rvalid;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      o_req = '{re: 1'b0, we: 1'b1, addr: a, wdata: d};
      @(negedge i_clk);
   endtask
   // idle lines toggle so stale values never look valid
   task automatic idle();
      o_req = '{re: 1'b0, we: 1'b0, addr: ~o_req.addr, wdata: ~o_req.wdata};
      @(negedge i_clk);
   endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ****************************************
   // stimulus, model and instances
   // ****************************************
   logic clk, rst, cs, os, abrt, filt, arc, clr, mlv, mhot, mpw, rvalid, vsum, tsum, psum;
   logic [15:0] uv, bow, bsw, cc, oc;
   logic [7:0] hot, cold, ac, rdata;
   logic [127:0] am, aa;
   logic [255:0] cm, ca;
   logic [2:0] athr;
   logic [4:0] cthr;
   logic [3:0] owthr;
   diag_fault_pkg::host_req_type req;
   diag_fault_pkg::power_first_type pf;
   diag_fault_pkg::power_second_type ps;
   logic [7:0] m [23];
   logic [31:0] seed = 32'h79a1;
   int errors = 0;
   int tests_run = 0;
   diag_fault_status_bank i_diag_fault_status_bank (
      .I_CORE_CLK(clk), .I_RST(rst), .I_HOST_REQ(req), .O_RDATA(rdata), .O_RVALID(rvalid),
      .I_CELL_LOW_VOLT_FLAG(uv), .I_INPUT_HOT_FLAG(hot), .I_INPUT_COLD_FLAG(cold),
      .I_AUX_MAIN_READING(am), .I_AUX_AUX_READING(aa), .I_CELL_MAIN_READING(cm),
      .I_CELL_AUX_READING(ca), .I_COMPARE_STROBE(cs), .I_AUX_COMPARE_THRESHOLD(athr),
      .I_CELL_COMPARE_THRESHOLD(cthr), .I_OPEN_WIRE_THRESHOLD(owthr), .I_OPEN_WIRE_STROBE(os),
      .I_BALANCE_OPEN_WIRE_FLAG(bow), .I_BALANCE_SWITCH_FLAG(bsw), .I_COMPARE_ABORT(abrt),
      .I_FILTER_DIAG_FLAG(filt), .I_POWER_FIRST(pf), .I_POWER_SECOND(ps),
      .I_ANALOG_LOW_RESET_CAUSE(arc), .I_FAULT_CLEAR(clr), .I_LOW_VOLT_SUMMARY_MASK(mlv),
      .I_HOT_SUMMARY_MASK(mhot), .I_POWER_SUMMARY_MASK(mpw), .O_VOLTAGE_SUMMARY_FLAG(vsum),
      .O_TEMPERATURE_SUMMARY_FLAG(tsum), .O_POWER_SUMMARY_FLAG(psum));
   host_model i_host_model (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_sim();
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // ****************************************
   // register sweep, summaries, random sources
   // ****************************************
   task automatic sweep(input bit w);
      logic [7:0] d;
      logic v;
      for (int i = 0; i < 23; i++) begin
         if (w) begin
            i_host_model.wr(16'h053e + 16'(i), 8'hff);
         end else begin
            i_host_model.rd(16'h053e + 16'(i), d, v);
            chk("rvalid", 8'h01, {7'h0, v});
            chk($sformatf("reg %h", 16'h053e + 16'(i)), m[i], d);
         end
      end
      i_host_model.idle();
      chk("rvalid idle", 8'h00, {7'h0, rvalid});
   endtask
   task automatic sums();
      chk("volt sum", {7'h0, !mlv && (m[0] | m[1]) != 8'h0}, {7'h0, vsum});
      chk("temp sum", {7'h0, !mhot && m[2] != 8'h0}, {7'h0, tsum});
      chk("pwr sum", {7'h0, !mpw && (m[20] | m[21] | m[22]) != 8'h0}, {7'h0, psum});
   endtask
   task automatic app();
      {m[0], m[1]} = {m[0], m[1]} | uv;
      m[2] |= hot;
      m[3] |= cold;
      m[5] |= ac;
      {m[7], m[8]} = {m[7], m[8]} | cc;
      {m[10], m[11]} = {m[10], m[11]} | oc;
      {m[13], m[14]} = {m[13], m[14]} | bow;
      {m[16], m[17]} = {m[16], m[17]} | bsw;
      m[18] |= {6'h0, abrt, filt};
      m[20] |= pf;
      m[21] |= {1'b0, ps[5], 1'b0, ps[4:0]};
      m[22] |= {7'h0, arc};
   endtask
   task automatic stim();
      logic [31:0] g;
      g = xs();
      uv = 16'(xs() & {32{g[0]}});
      hot = 8'(xs() & {32{g[1]}});
      cold = 8'(xs());
      bow = 16'(xs());
      bsw = 16'(xs() & xs());
      pf = 8'(xs() & {32{g[5]}});
      ps = 6'(xs() & {32{g[6]}});
      {abrt, filt, arc, cs, os, mlv, mhot, mpw} = g[9:2];
      {athr, cthr, owthr} = g[21:10];
      for (int i = 0; i < 16; i++) begin
         g = xs();
         cm[i*16+:16] = {11'h0, g[4:0]};
         ca[i*16+:16] = {11'h0, g[4:0]} + 16'(g[9:5]);
         cc[i] = cs && (g[9:5] > cthr);
         oc[i] = os && (g[4:0] < 5'(owthr));
         if (i < 8) begin
            am[i*16+:16] = {1'b0, g[30:16]};
            aa[i*16+:16] = {1'b0, g[30:16]} + 16'(g[12:10]);
            ac[i] = cs && (g[12:10] > athr);
         end
      end
      app();
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      {cs, os, abrt, filt, arc, clr, mlv, mhot, mpw, uv, bow, bsw, hot, cold} = '0;
      {am, aa, cm, ca, athr, cthr, owthr, pf, ps, cc, oc, ac} = '0;
      m = '{default: 8'h00};
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      sweep(1'b0);
      sums();
      $display("reset values done");
      for (int n = 0; n < 40; n++) begin
         stim();
         repeat (2) @(negedge clk);
         sums();
         sweep(1'b0);
         // sources held: set must win over the clear
         clr = 1'b1;
         @(negedge clk);
         clr = 1'b0;
         m = '{default: 8'h00};
         app();
         @(negedge clk);
         sums();
         sweep(1'b0);
      end
      $display("random flags done");
      sweep(1'b1);
      sweep(1'b0);
      $display("write attempts done");
      end_sim();
   end
endmodule
`default_nettype wire
